// File: dv/pcs_dead_band_model.sv
// Behavioural upstream dead-band stage feeding the chopper channels.
`timescale 1ns/10ps
`default_nettype none

module pcs_dead_band_model (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire pcs_pkg::pcs_pair_s  want,
  output var  pcs_pkg::pcs_pair_s  chan
);
  // Bypassed stage: forwards the action levels through one register.
  always_ff @(posedge sys_clk) begin
    chan <= rst ? 2'h0 : want;
  end
endmodule

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the chopper stage.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic               sys_clk   = 1'b0;
  logic               rst       = 1'b1;
  logic               reg_wr    = 1'b0;
  logic               reg_rd    = 1'b0;
  logic [3:0]         reg_addr  = 4'h0;
  logic [15:0]        reg_wdata = 16'h0000;
  logic [15:0]        reg_rdata;
  logic [15:0]        v;
  pcs_pkg::pcs_pair_s want      = 2'h0;
  pcs_pkg::pcs_pair_s chan_in;
  pcs_pkg::pcs_pair_s chan_out;
  int                 n_errors  = 0;
  int                 checks    = 0;
  int                 cyc       = 0;

  pcs_dead_band_model i_src (.sys_clk(sys_clk), .rst(rst), .want(want), .chan(chan_in));
  pcs_chopper i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_in(chan_in), .chan_out(chan_out));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic t_regs;
    rd(4'h0, v);
    chk(v, 16'h0000, "control after reset");
    @(posedge sys_clk);
    #1 chk(reg_rdata, 16'h0000, "read data stands one cycle");
    rd(4'h1, v);
    chk(v & 16'hffef, 16'h0000, "status after reset");
    wr(4'h0, 16'hfeff);
    rd(4'h0, v);
    chk(v, 16'h06ff, "control fields and reserved bits");
    wr(4'h1, 16'h0000);
    wr(4'h9, 16'h0000);
    rd(4'h0, v);
    chk(v, 16'h06ff, "status and unmapped writes ignored");
    rd(4'h9, v);
    chk(v, 16'h0000, "unmapped read");
    wr(4'h0, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_bypass;
    pcs_pkg::pcs_pair_s prev;
    prev = 2'h0;
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      want <= 2'(i * 3 + i / 4);
      #1 chk(16'(chan_out), 16'(prev), "bypass follows input");
      prev = chan_in;
    end
    @(posedge sys_clk);
    want <= 2'h0;
    $display("test bypass done");
  endtask

  task automatic t_chop(input logic [3:0] w, input logic [2:0] f, input logic [2:0] d);
    int hi;
    wr(4'h0, {5'h00, d, f, w, 1'b1});
    @(posedge sys_clk);
    want <= 2'h3;
    @(posedge sys_clk);
    hi = 0;
    repeat (8 * (w + 1)) begin
      @(posedge sys_clk);
      #1 hi += int'(chan_out === 2'h3);
    end
    chk(16'(hi), 16'(8 * (w + 1)), "first pulse width");
    hi = 0;
    repeat (8 * (f + 1)) begin
      @(posedge sys_clk);
      #1 hi += int'(chan_out === 2'h3);
    end
    chk(16'(hi), 16'((d + 1) * (f + 1)), "carrier high time per period");
    @(posedge sys_clk);
    want <= 2'h0;
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(chan_out), 16'h0000, "low input forces low output");
    $display("test chop %h %h %h done", w, f, d);
  endtask

  task automatic t_status;
    wr(4'h0, 16'h001f);
    @(posedge sys_clk);
    want <= 2'h3;
    repeat (4) @(posedge sys_clk);
    rd(4'h1, v);
    chk(v & 16'hffef, 16'h000f, "status during first pulse");
    @(posedge sys_clk);
    want <= 2'h0;
    repeat (2) @(posedge sys_clk);
    rd(4'h1, v);
    chk(v & 16'hffef, 16'h0000, "status after input low");
    $display("test status done");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_bypass();
    t_status();
    t_chop(4'h0, 3'h0, 3'h0);
    t_chop(4'hf, 3'h7, 3'h6);
    t_chop(4'h3, 3'h2, 3'h3);
    t_chop(4'h1, 3'h0, 3'h3);
    report_and_stop();
  end
endmodule

`default_nettype wire

// File: rtl/pcs_channel.sv
// One chopped channel: first pulse, carrier gating and bypass.
`timescale 1ns/10ps
`default_nettype none

module pcs_channel (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      chop_en,
  input  wire logic [pcs_pkg::PW_W-1:0]  width_sel,
  input  wire logic                      carrier,
  input  wire logic                      chan_in,
  output logic                           chan_out,
  output logic                           pulse_active
);

  logic                     in_prev;
  logic [pcs_pkg::OS_W-1:0] os_cnt;
  logic [pcs_pkg::OS_W-1:0] next_os_cnt;
  wire                      rise     = chan_in && !in_prev;
  wire                      os_run   = rise || (os_cnt != '0);
  wire                      chop_val = chan_in && (os_run || carrier);
  wire                      next_out = chop_en ? chop_val : chan_in;

  always_comb begin
    next_os_cnt = '0;
    if (chop_en && chan_in) begin
      if (rise) begin
        next_os_cnt = pcs_pkg::pulse_last(width_sel);
      end else if (os_cnt != '0) begin
        next_os_cnt = os_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_prev      <= 1'b0;
      os_cnt       <= '0;
      chan_out     <= 1'b0;
      pulse_active <= 1'b0;
    end else begin
      in_prev      <= chan_in;
      os_cnt       <= next_os_cnt;
      chan_out     <= next_out;
      pulse_active <= chop_en && os_run;
    end
  end

  sequence s_start;
    chop_en && rise && width_sel == '0;
  endsequence

  sequence s_held;
    (chop_en && chan_in && width_sel == '0) [*7];
  endsequence

  property p_first_pulse;
    @(posedge sys_clk) disable iff (rst)
      s_start ##1 s_held |-> $past(chan_out, 6) && chan_out;
  endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("first pulse too short");

  property p_low_input;
    @(posedge sys_clk) disable iff (rst)
      (chop_en && !chan_in) |=> !chan_out;
  endproperty
  a_low_input: assert property (p_low_input) else $error("output high with low input");

  property p_bypass;
    @(posedge sys_clk) disable iff (rst)
      !chop_en |=> chan_out == $past(chan_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not pass input");

  property p_rise_starts;
    @(posedge sys_clk) disable iff (rst)
      (chop_en && rise) |=> chan_out && pulse_active;
  endproperty
  a_rise_starts: assert property (p_rise_starts) else $error("rise did not start pulse");

endmodule

`default_nettype wire

// File: rtl/pcs_chopper.sv
// Chopper stage top: control register, shared carrier and two channels.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Enable low passes inputs; high chops both.
// - Carrier period is eight clocks times code+1.
// - Carrier high for code+1 eighths; 111 reserved.
// - First pulse lasts eight clocks times code+1.
// - Channel inputs come from the dead-band stage.
module pcs_chopper (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [pcs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pcs_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pcs_pkg::DATA_W-1:0]  reg_rdata,
  input  wire pcs_pkg::pcs_pair_s          chan_in,
  output pcs_pkg::pcs_pair_s               chan_out
);

  pcs_pkg::pcs_ctrl_s      ctrl;
  logic [pcs_pkg::PH_W-1:0] phase;
  logic [pcs_pkg::PH_W-1:0] next_phase;
  logic                     carrier;
  pcs_pkg::pcs_pair_s       pulse_active;
  logic [pcs_pkg::DATA_W-1:0] next_rdata;

  wire ctrl_sel = (reg_addr == pcs_pkg::CTRL_ADDR);
  wire stat_sel = (reg_addr == pcs_pkg::STAT_ADDR);
  wire ctrl_wr  = reg_wr && ctrl_sel;

  wire [pcs_pkg::PH_W-1:0] period    = pcs_pkg::carrier_period(ctrl.carrier_divider_sel);
  wire [pcs_pkg::PH_W-1:0] high_time = pcs_pkg::carrier_high(ctrl.carrier_duty_sel,
                                                             ctrl.carrier_divider_sel);
  wire                     phase_end = (phase >= period - 1'b1);
  wire                     next_carrier;

  pcs_pkg::pcs_stat_s      stat;

  assign next_phase   = phase_end ? '0 : phase + 1'b1;
  assign next_carrier = (next_phase < high_time);
  assign stat.carrier      = carrier;
  assign stat.pulse_active = pulse_active;
  assign stat.chan_out     = chan_out;

  assign next_rdata = !reg_rd   ? '0 :
                      ctrl_sel  ? pcs_pkg::DATA_W'(ctrl) :
                      stat_sel  ? pcs_pkg::DATA_W'(stat) : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= pcs_pkg::pcs_ctrl_s'(pcs_pkg::CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl <= pcs_pkg::pcs_ctrl_s'(reg_wdata[pcs_pkg::CTRL_W-1:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase   <= '0;
      carrier <= 1'b1;
    end else begin
      phase   <= next_phase;
      carrier <= next_carrier;
    end
  end

  // Both channels share one carrier so their chopping stays in phase.
  wire [1:0] in_vec = chan_in;
  wire [1:0] out_vec;
  wire [1:0] act_vec;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      pcs_channel u_chan (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .chop_en      (ctrl.chopper_enable),
        .width_sel    (ctrl.first_pulse_width),
        .carrier      (carrier),
        .chan_in      (in_vec[gi]),
        .chan_out     (out_vec[gi]),
        .pulse_active (act_vec[gi])
      );
    end
  endgenerate

  assign chan_out     = pcs_pkg::pcs_pair_s'(out_vec);
  assign pulse_active = pcs_pkg::pcs_pair_s'(act_vec);

  sequence s_period_end;
    phase_end && $stable(ctrl.carrier_divider_sel);
  endsequence

  property p_phase_wrap;
    @(posedge sys_clk) disable iff (rst)
      s_period_end |=> phase == '0;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("carrier phase did not wrap");

  property p_div1_period;
    @(posedge sys_clk) disable iff (rst)
      (phase == '0 && ctrl.carrier_divider_sel == '0 && !ctrl_wr) ##1 !ctrl_wr [*7]
        |=> phase == '0;
  endproperty
  a_div1_period: assert property (p_div1_period) else $error("carrier period not eight");

  property p_carrier_start;
    @(posedge sys_clk) disable iff (rst)
      (phase == '0) |-> carrier;
  endproperty
  a_carrier_start: assert property (p_carrier_start) else $error("carrier low at start");

  property p_carrier_end;
    @(posedge sys_clk) disable iff (rst)
      (phase_end && ctrl.carrier_duty_sel != pcs_pkg::DUTY_RSVD && $stable(ctrl))
        |-> !carrier;
  endproperty
  a_carrier_end: assert property (p_carrier_end) else $error("carrier high at end");

  sequence s_half_window;
    (phase == '0 && ctrl.carrier_duty_sel == 3'h3 && ctrl.carrier_divider_sel == '0
     && !ctrl_wr) ##1 !ctrl_wr [*3];
  endsequence

  property p_half_duty;
    @(posedge sys_clk) disable iff (rst)
      s_half_window |->
        ($past(carrier, 3) && $past(carrier, 2) && $past(carrier) && carrier) ##1 !carrier;
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("half duty carrier wrong");

  property p_read_ctrl;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && ctrl_sel && !reg_wr) |=> reg_rdata == pcs_pkg::DATA_W'($past(ctrl));
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong");

  property p_read_idle;
    @(posedge sys_clk) disable iff (rst)
      !reg_rd |=> reg_rdata == '0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle zero");

  property p_write_takes;
    @(posedge sys_clk) disable iff (rst)
      ctrl_wr |=> ctrl.chopper_enable == $past(reg_wdata[0]);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("enable write lost");

  property p_fields_take;
    @(posedge sys_clk) disable iff (rst)
      ctrl_wr |=> ctrl == pcs_pkg::pcs_ctrl_s'($past(reg_wdata[pcs_pkg::CTRL_W-1:0]));
  endproperty
  a_fields_take: assert property (p_fields_take) else $error("control field lost");

  property p_ctrl_hold;
    @(posedge sys_clk) disable iff (rst)
      !ctrl_wr |=> $stable(ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  property p_read_stat;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && stat_sel) |=> reg_rdata == pcs_pkg::DATA_W'($past(stat));
  endproperty
  a_read_stat: assert property (p_read_stat) else $error("status readback wrong");

  property p_read_unmapped;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && !ctrl_sel && !stat_sel) |=> reg_rdata == '0;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_rdata_upper;
    @(posedge sys_clk) disable iff (rst)
      reg_rdata[pcs_pkg::DATA_W-1:pcs_pkg::CTRL_W] == '0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("reserved read bits set");

  property p_phase_step;
    @(posedge sys_clk) disable iff (rst)
      !phase_end |=> phase == $past(phase) + 1'b1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("carrier phase skipped");

  property p_phase_range;
    @(posedge sys_clk) disable iff (rst)
      $stable(ctrl.carrier_divider_sel) |-> phase < period;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("carrier phase past period");

  property p_carrier_level;
    @(posedge sys_clk) disable iff (rst)
      $stable(ctrl) |-> carrier == (phase < high_time);
  endproperty
  a_carrier_level: assert property (p_carrier_level) else $error("carrier level wrong");

  property p_pulse_idle;
    @(posedge sys_clk) disable iff (rst)
      !ctrl.chopper_enable |=> pulse_active == '0;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("first pulse while bypassed");

  property p_both_low;
    @(posedge sys_clk) disable iff (rst)
      (ctrl.chopper_enable && chan_in == '0) |=> chan_out == '0;
  endproperty
  a_both_low: assert property (p_both_low) else $error("chopped output with inputs low");

  property p_out_needs_in;
    @(posedge sys_clk) disable iff (rst)
      (chan_out & ~$past(chan_in)) == '0;
  endproperty
  a_out_needs_in: assert property (p_out_needs_in) else $error("output without input");

endmodule

`default_nettype wire

// File: rtl/pcs_pkg.sv
// Constants, field layouts and carrier and pulse functions for the chopper stage.
package pcs_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h1;

  localparam int CTRL_W = 11;
  localparam int STAT_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  localparam int PW_W   = 4;
  localparam int FQ_W   = 3;
  localparam int DY_W   = 3;
  localparam int PH_W   = 7;
  localparam int OS_W   = 7;

  localparam int BASE_DIV = 8;
  localparam logic [DY_W-1:0] DUTY_RSVD = 3'h7;

  typedef struct packed {
    logic b;
    logic a;
  } pcs_pair_s;

  typedef struct packed {
    logic [DY_W-1:0] carrier_duty_sel;
    logic [FQ_W-1:0] carrier_divider_sel;
    logic [PW_W-1:0] first_pulse_width;
    logic            chopper_enable;
  } pcs_ctrl_s;

  typedef struct packed {
    logic      carrier;
    pcs_pair_s pulse_active;
    pcs_pair_s chan_out;
  } pcs_stat_s;

  function automatic logic [PH_W-1:0] carrier_period(input logic [FQ_W-1:0] sel);
    carrier_period = PH_W'((int'(sel) + 1) * BASE_DIV);
  endfunction

  function automatic logic [PH_W-1:0] carrier_high(input logic [DY_W-1:0] duty,
                                                   input logic [FQ_W-1:0] sel);
    carrier_high = PH_W'((int'(duty) + 1) * (int'(sel) + 1));
  endfunction

  function automatic logic [OS_W-1:0] pulse_last(input logic [PW_W-1:0] sel);
    pulse_last = OS_W'((int'(sel) + 1) * BASE_DIV - 1);
  endfunction

endpackage
